// [rtl/odwp_pkg.sv]
package odwp_pkg;
   // =========================================
   // Bus framing
   localparam int ODWP_NUM_CH = 8;
   localparam int ODWP_CODE_W = 12;
   localparam logic [6:0] ODWP_ADDR_BASE = 7'h48;
   localparam logic [7:0] ODWP_HS_MASTER_CODE = 8'h08;
   localparam logic [3:0] ODWP_CMD_WRITE_UPDATE = 4'h3;
   localparam logic [3:0] ODWP_ACCESS_ALL = 4'hf;
   localparam logic [2:0] ODWP_BIT_LAST = 3'h7;
   localparam logic [11:0] ODWP_CODE_RESET = 12'h000;
   // Resolution variants: 12, 10 or 8 code bits
   localparam logic [1:0] ODWP_RES_12 = 2'h0;
   localparam logic [1:0] ODWP_RES_10 = 2'h1;
   localparam logic [1:0] ODWP_RES_8 = 2'h2;
   // Address-select pin levels, the small package uses only the first three
   localparam logic [2:0] ODWP_SEL_COUNT_SMALL = 3'h3;

   typedef enum logic [2:0] {
      ODWP_IDLE,
      ODWP_ADDR,
      ODWP_CMD,
      ODWP_UPPER,
      ODWP_LOWER,
      ODWP_SKIP
   } odwp_state_type;
endpackage

// [rtl/odwp_sync.sv]
module odwp_sync
   import odwp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);
   logic stage1;

   // =========================================
   // Two-flop synchroniser
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stage1 <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// [rtl/odwp_top.sv]
// Contract
// - After the command byte, byte pairs rewrite the channel until stop.
// - The channel updates at the clock fall ending each lower-byte ack.
// - Write-and-update with access nibble all ones writes every channel.
// - The master code is not acknowledged; a repeated start follows.
// - All bus speeds work and the clock line is never held low.
// - The select pin picks one of three (small) or eight (large) addresses.
// - With the select pin low the device answers write address 1001 0000.
// - Channel codes are straight binary of 12, 10 or 8 bits per variant.
// - The access nibble selects the channel, code six being channel G.
module odwp_top
   import odwp_pkg::*;
#(
   parameter logic [1:0] RESOLUTION = ODWP_RES_12,
   parameter logic LARGE_PACKAGE = 1'b0
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic scl_oe,
   input wire logic [2:0] address_select_pin,
   output logic [ODWP_NUM_CH*ODWP_CODE_W-1:0] channel_code,
   output logic [ODWP_NUM_CH-1:0] channel_update,
   output logic hs_mode
);
   logic scl_s, sda_s, scl_d, sda_d;
   logic [2:0] sel_s1, sel_s2;
   odwp_state_type state;
   logic [2:0] bit_cnt;
   logic [7:0] shreg;
   logic ack_phase, ack_drive, ack_lower, ack_slot;
   logic [3:0] cmd_nib, acc_nib;
   logic [7:0] upper_data_byte;
   logic [7:0] lower_data_byte;
   logic [6:0] my_addr;
   logic start_cond, stop_cond, scl_rise, scl_fall;
   logic [7:0] next_byte;
   logic [ODWP_CODE_W-1:0] next_code;

   odwp_sync u_scl (.core_clk(core_clk), .rst(rst), .async_in(scl_in),
      .sync_out(scl_s));
   odwp_sync u_sda (.core_clk(core_clk), .rst(rst), .async_in(sda_in),
      .sync_out(sda_s));

   // =========================================
   // Address-select synchroniser
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sel_s1 <= 3'h0;
         sel_s2 <= 3'h0;
      end else begin
         sel_s1 <= address_select_pin;
         sel_s2 <= sel_s1;
      end
   end

   always_comb begin
      if (!LARGE_PACKAGE && sel_s2 >= ODWP_SEL_COUNT_SMALL)
         my_addr = ODWP_ADDR_BASE;
      else
         my_addr = ODWP_ADDR_BASE | {4'h0, sel_s2};
   end

   // =========================================
   // Edge and condition detect
   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign start_cond = scl_s && scl_d && sda_d && !sda_s;
   assign stop_cond = scl_s && scl_d && !sda_d && sda_s;
   assign next_byte = {shreg[6:0], sda_s};

   always_comb begin
      unique case (RESOLUTION)
         ODWP_RES_10: next_code = {2'h0, upper_data_byte,
                                   lower_data_byte[7:6]};
         ODWP_RES_8: next_code = {4'h0, upper_data_byte};
         default: next_code = {upper_data_byte, lower_data_byte[7:4]};
      endcase
   end

   // =========================================
   // Byte engine
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= ODWP_IDLE;
         bit_cnt <= 3'h0;
         shreg <= 8'h00;
         ack_phase <= 1'b0;
         ack_drive <= 1'b0;
         ack_lower <= 1'b0;
         ack_slot <= 1'b0;
         cmd_nib <= 4'h0;
         acc_nib <= 4'h0;
         upper_data_byte <= 8'h00;
         lower_data_byte <= 8'h00;
         hs_mode <= 1'b0;
      end else if (stop_cond) begin
         state <= ODWP_IDLE;
         ack_phase <= 1'b0;
         ack_drive <= 1'b0;
         ack_lower <= 1'b0;
         ack_slot <= 1'b0;
         hs_mode <= 1'b0;
      end else if (start_cond) begin
         state <= ODWP_ADDR;
         bit_cnt <= 3'h0;
         ack_slot <= 1'b0;
         ack_phase <= 1'b0;
         ack_drive <= 1'b0;
         ack_lower <= 1'b0;
      end else if (scl_rise && !ack_phase && state != ODWP_IDLE) begin
         shreg <= next_byte;
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == ODWP_BIT_LAST) begin
            ack_phase <= 1'b1;
            ack_drive <= 1'b0;
            ack_lower <= 1'b0;
            unique case (state)
               ODWP_ADDR: begin
                  if (next_byte == ODWP_HS_MASTER_CODE) begin
                     hs_mode <= 1'b1;
                     state <= ODWP_SKIP;
                  end else if (next_byte == {my_addr, 1'b0}) begin
                     ack_drive <= 1'b1;
                     state <= ODWP_CMD;
                  end else begin
                     state <= ODWP_SKIP;
                  end
               end
               ODWP_CMD: begin
                  cmd_nib <= next_byte[7:4];
                  acc_nib <= next_byte[3:0];
                  ack_drive <= 1'b1;
                  state <= ODWP_UPPER;
               end
               ODWP_UPPER: begin
                  upper_data_byte <= next_byte;
                  ack_drive <= 1'b1;
                  state <= ODWP_LOWER;
               end
               ODWP_LOWER: begin
                  lower_data_byte <= next_byte;
                  ack_drive <= 1'b1;
                  ack_lower <= 1'b1;
                  state <= ODWP_UPPER;
               end
               default: state <= ODWP_SKIP;
            endcase
         end
      end else if (scl_fall && ack_phase && !ack_slot) begin
         // Ninth bit slot opens when the eighth clock falls
         ack_slot <= 1'b1;
      end else if (scl_fall && ack_slot) begin
         // Ninth clock falls, ack slot over
         ack_phase <= 1'b0;
         ack_slot <= 1'b0;
         ack_drive <= 1'b0;
         ack_lower <= 1'b0;
      end
   end

   // =========================================
   // Acknowledge driver
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sda_out <= 1'b1;
         sda_oe <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         sda_oe <= ack_drive && ack_slot && !stop_cond;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) scl_oe <= 1'b0;
      else scl_oe <= 1'b0;
   end

   // =========================================
   // Channel codes and update strobes
   genvar ch;
   generate
      for (ch = 0; ch < ODWP_NUM_CH; ch++) begin : g_ch
         logic hit;
         assign hit = (cmd_nib == ODWP_CMD_WRITE_UPDATE &&
                       acc_nib == ODWP_ACCESS_ALL) ||
                      acc_nib == 4'(ch);
         always_ff @(posedge core_clk) begin
            if (rst) begin
               channel_code[ch*ODWP_CODE_W +: ODWP_CODE_W] <= ODWP_CODE_RESET;
               channel_update[ch] <= 1'b0;
            end else begin
               channel_update[ch] <= 1'b0;
               if (scl_fall && ack_slot && ack_lower && hit
                   && !start_cond && !stop_cond) begin
                  channel_code[ch*ODWP_CODE_W +: ODWP_CODE_W] <= next_code;
                  channel_update[ch] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // =========================================
   // Checks
   AST_NO_STRETCH: assert property (@(posedge core_clk) disable iff (rst)
      !scl_oe) else $error("clock line driven");
   AST_UPD_ON_FALL: assert property (@(posedge core_clk) disable iff (rst)
      |channel_update |-> $past(scl_fall) && $past(ack_lower))
      else $error("update outside lower-byte ack");
   AST_ACK_LOW: assert property (@(posedge core_clk) disable iff (rst)
      sda_oe |-> !sda_out) else $error("ack drives high");
   AST_HS_NOACK: assert property (@(posedge core_clk) disable iff (rst)
      $rose(hs_mode) |-> ##1 !ack_drive)
      else $error("master code acked");
   AST_ACK_SCL_LOW: assert property (@(posedge core_clk) disable iff (rst)
      $changed(sda_oe) |-> !scl_s)
      else $error("ack edge while clock high");
   AST_BCAST: assert property (@(posedge core_clk) disable iff (rst)
      (|channel_update && cmd_nib == ODWP_CMD_WRITE_UPDATE
       && acc_nib == ODWP_ACCESS_ALL) |-> &channel_update)
      else $error("broadcast missed a channel");
   AST_ONEHOT: assert property (@(posedge core_clk) disable iff (rst)
      (|channel_update && acc_nib < 4'h8 &&
       cmd_nib != ODWP_CMD_WRITE_UPDATE) |-> $onehot(channel_update))
      else $error("single write hit many");
   AST_PAIR: assert property (@(posedge core_clk) disable iff (rst)
      |channel_update |-> state == ODWP_UPPER)
      else $error("update not followed by next pair");
   AST_CODE: assert property (@(posedge core_clk) disable iff (rst)
      channel_update[0] |-> channel_code[ODWP_CODE_W-1:0] == $past(next_code))
      else $error("code not loaded");
   AST_ADDR: assert property (@(posedge core_clk) disable iff (rst)
      my_addr[6:3] == ODWP_ADDR_BASE[6:3]) else $error("bad address");
   AST_RANGE: assert property (@(posedge core_clk) disable iff (rst)
      RESOLUTION == ODWP_RES_8 |-> channel_code[11:8] == 4'h0)
      else $error("code exceeds 8 bits");

   COV_UPDATE: cover property (@(posedge core_clk) |channel_update);
   COV_BCAST: cover property (@(posedge core_clk) &channel_update);
   COV_HS: cover property (@(posedge core_clk) $rose(hs_mode));
endmodule

// [tb/odwp_bus_ctrl.sv]
module odwp_bus_ctrl (
   input wire logic core_clk,
   input wire logic sda_oe,
   input wire logic sda_out,
   input wire logic scl_oe,
   output logic scl_line,
   output logic sda_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==============================
   // Open-drain lines with pull-ups
   logic scl_drv = 1'b1;
   logic sda_drv = 1'b1;
   assign scl_line = scl_drv && !scl_oe;
   assign sda_line = sda_drv && !(sda_oe && !sda_out);
   task automatic gap();
      repeat (6) @(posedge core_clk);
   endtask
   task automatic start();
      sda_drv <= 1'b1;
      gap();
      scl_drv <= 1'b1;
      gap();
      sda_drv <= 1'b0;
      gap();
      scl_drv <= 1'b0;
      gap();
   endtask
   task automatic stop();
      sda_drv <= 1'b0;
      gap();
      scl_drv <= 1'b1;
      gap();
      sda_drv <= 1'b1;
      gap();
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_drv <= b[i];
         gap();
         scl_drv <= 1'b1;
         gap();
         scl_drv <= 1'b0;
         gap();
      end
      sda_drv <= 1'b1;
      gap();
      scl_drv <= 1'b1;
      gap();
      ack = !sda_line;
      scl_drv <= 1'b0;
      gap();
   endtask
endmodule

// [tb/tb_top.sv]
module tb_top
   import odwp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic scl_in, sda_in, sda_out, sda_oe, scl_oe, hs_mode, ack;
   logic [2:0] pin = 3'h0;
   logic [ODWP_NUM_CH*ODWP_CODE_W-1:0] channel_code;
   logic [7:0] channel_update;
   logic [7:0] upd_seen = 8'h00;
   logic upd_clr = 1'b0;
   logic scl_hold = 1'b0;
   int fails = 0;
   int compares = 0;
   int cycles = 0;
   int exp_code[8] = '{default: 0};
   odwp_top #(.RESOLUTION(ODWP_RES_12), .LARGE_PACKAGE(1'b0)) odwp_top_i (
      .core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .scl_oe(scl_oe),
      .address_select_pin(pin), .channel_code(channel_code),
      .channel_update(channel_update), .hs_mode(hs_mode));
   odwp_bus_ctrl odwp_bus_ctrl_i (
      .core_clk(core_clk), .sda_oe(sda_oe), .sda_out(sda_out),
      .scl_oe(scl_oe), .scl_line(scl_in), .sda_line(sda_in));
   initial forever #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      upd_seen <= upd_clr ? 8'h00 : upd_seen | channel_update;
      scl_hold <= scl_hold | scl_oe;
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic check(input string name, input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic put(input logic [7:0] b, input logic exp_ack);
      odwp_bus_ctrl_i.send(b, ack);
      check("ack", {15'h0, ack}, {15'h0, exp_ack});
   endtask
   // =====================================
   // One data pair with expected update
   task automatic pair(input int code, input logic [7:0] mask);
      logic [7:0] lo;
      lo = {code[3:0], 4'($urandom)};
      upd_clr <= 1'b1;
      @(posedge core_clk);
      upd_clr <= 1'b0;
      put(code[11:4], 1'b1);
      check("early update", {8'h0, upd_seen}, 16'h0);
      put(lo, 1'b1);
      repeat (4) @(posedge core_clk);
      for (int c = 0; c < 8; c++) begin
         if (mask[c])
            exp_code[c] = code;
         check("code", 16'(channel_code[c*12 +: 12]),
            16'(exp_code[c]));
      end
      check("update", {8'h0, upd_seen}, {8'h0, mask});
   endtask
   // ==============
   // Main sequence
   initial begin
      void'($urandom(32'h9991));
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      check("reset", {13'h0, |channel_code, sda_oe, hs_mode}, 16'h0);
      odwp_bus_ctrl_i.start();
      put(8'h90, 1'b1);
      put(8'h05, 1'b1);
      pair(4095, 8'h20);
      pair(1024, 8'h20);
      odwp_bus_ctrl_i.stop();
      for (int c = 0; c < 8; c++) begin
         odwp_bus_ctrl_i.start();
         put(8'h90, 1'b1);
         put({4'h3, 4'(c)}, 1'b1);
         pair(int'($urandom_range(4095)), 8'(1 << c));
         odwp_bus_ctrl_i.stop();
      end
      odwp_bus_ctrl_i.start();
      put(ODWP_HS_MASTER_CODE, 1'b0);
      check("hs", {15'h0, hs_mode}, 16'h1);
      odwp_bus_ctrl_i.start();
      put(8'h90, 1'b1);
      put(8'h3f, 1'b1);
      pair(2048, 8'hff);
      pair(int'($urandom_range(4095)), 8'hff);
      odwp_bus_ctrl_i.stop();
      repeat (8) @(posedge core_clk);
      check("hs end", {15'h0, hs_mode}, 16'h0);
      pin <= 3'h2;
      repeat (8) @(posedge core_clk);
      odwp_bus_ctrl_i.start();
      put(8'h90, 1'b0);
      odwp_bus_ctrl_i.stop();
      odwp_bus_ctrl_i.start();
      put(8'h94, 1'b1);
      put(8'h31, 1'b1);
      pair(int'($urandom_range(4095)), 8'h02);
      odwp_bus_ctrl_i.stop();
      odwp_bus_ctrl_i.start();
      put(8'h95, 1'b0);
      odwp_bus_ctrl_i.stop();
      check("stretch", {15'h0, scl_hold}, 16'h0);
      end_of_test();
   end
endmodule
